// >>> shared/tx_slot_pkg.sv
`default_nettype none
package tx_slot_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int STRB_W = DATA_W / 8;

	localparam logic [ADDR_W-1:0] OFS_SLOT_MASK  = 8'hb8;
	localparam logic [ADDR_W-1:0] OFS_INT_ENABLE = 8'hbc;
	localparam logic [ADDR_W-1:0] OFS_STATUS     = 8'hc0;
	localparam logic [ADDR_W-1:0] OFS_SLOT_STATE = 8'hc4;

	localparam logic [DATA_W-1:0] SLOT_MASK_RESET  = 32'h0000_0000;
	localparam logic [DATA_W-1:0] INT_ENABLE_RESET = 32'h0000_0000;
	localparam logic [7:0]        STATUS_RESET     = 8'h00;

	localparam int EN_FRAME_START = 7;
	localparam int EN_DATA_READY  = 5;
	localparam int EN_FINAL_SLOT  = 4;
	localparam int EN_DMA_ERR     = 3;
	localparam int EN_CLK_FAIL    = 2;
	localparam int EN_SYNC        = 1;
	localparam int EN_UNDERRUN    = 0;
	localparam logic [DATA_W-1:0] INT_ENABLE_WMASK = 32'h0000_00bf;

	localparam int ST_DMA_ERR     = 7;
	localparam int ST_FRAME_START = 6;
	localparam int ST_DATA_READY  = 5;
	localparam int ST_FINAL_SLOT  = 4;
	localparam int ST_CLK_FAIL    = 2;
	localparam int ST_SYNC        = 1;
	localparam int ST_UNDERRUN    = 0;
	localparam int ST_ANY_ERROR   = 8;
	localparam logic [7:0] STATUS_FLAG_MASK = 8'hf7;

	localparam int SLOT_COUNT  = 384;
	localparam int SLOT_W      = 9;
	localparam int MASK_PERIOD = 32;
	localparam int MASK_SEL_W  = 5;
	localparam int SLOT_ACTIVE_POS = 16;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic frame_start;
		logic data_ready;
		logic final_slot;
		logic dma_err;
		logic clk_fail;
		logic unexpected_sync;
		logic underrun;
	} tx_events_s;

	typedef struct packed {
		logic              awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic              wvalid;
		logic [DATA_W-1:0] wdata;
		logic [STRB_W-1:0] wstrb;
		logic              bready;
		logic              arvalid;
		logic [ADDR_W-1:0] araddr;
		logic              rready;
	} axil_req_s;

	typedef struct packed {
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0]        rresp;
	} axil_rsp_s;

endpackage
`default_nettype wire

// >>> hw/tx_slot_select.sv
`timescale 1ns/1ps
`default_nettype none
module tx_slot_select #(
	parameter int SER_N = 4
) (
	input  wire logic                            clk,
	input  wire logic                            reset_n,
	input  wire logic [tx_slot_pkg::DATA_W-1:0]  slot_mask,
	input  wire logic [tx_slot_pkg::SLOT_W-1:0]  slot_number,
	input  wire logic                            slot_valid,
	input  wire logic [SER_N-1:0]                ser_shift_req,
	output logic                                 slot_active,
	output logic [SER_N-1:0]                     ser_shift_en
);

	typedef struct packed {
		logic             active;
		logic [SER_N-1:0] shift_en;
	} sel_state_s;

	sel_state_s state_ff;
	sel_state_s nxt_state;
	logic [tx_slot_pkg::MASK_SEL_W-1:0] mask_sel;
	logic                               mask_bit;

	// Low bits of the slot number give the slot modulo the mask period.
	assign mask_sel = slot_number[tx_slot_pkg::MASK_SEL_W-1:0]; // see [RULE2]
	assign mask_bit = slot_mask[mask_sel]; // see [RULE2]

	always_comb begin
		nxt_state = state_ff;
		nxt_state.active = slot_valid & mask_bit;
		// A masked slot silences every serializer, whatever it asks for.
		if (slot_valid && mask_bit) begin
			nxt_state.shift_en = ser_shift_req; // see [RULE4]
		end else begin
			nxt_state.shift_en = '0; // see [RULE3]
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign slot_active  = state_ff.active;
	assign ser_shift_en = state_ff.shift_en;

endmodule // tx_slot_select
`default_nettype wire

// >>> hw/tx_slot_gate.sv
// Functional notes
// [RULE1] The transmit slot counter covers up to 384 slots per frame.
// [RULE2] The active bit for a slot is mask bit slot number modulo 32.
// [RULE3] A slot whose mask bit is 0 shifts no data on any serializer.
// [RULE4] A slot whose mask bit is 1 shifts data as each serializer asks.
// [RULE5] The transmit interrupt rises only for conditions enabled by 1.
// [RULE6] Enable bit 7 gates the start of frame condition.
// [RULE7] Enable bit 5 gates the data ready condition.
// [RULE8] Enable bit 4 gates the last slot condition.
// [RULE9] Enable bit 3 gates the DMA error condition.
// [RULE10] Enable bit 2 gates the clock failure condition.
// [RULE11] Enable bit 1 gates the unexpected frame sync condition.
// [RULE12] Enable bit 0 gates the underrun condition.
// [RULE13] Enable bits 31 to 8 and 6 read zero and ignore writes.
// [RULE14] Software should write zero to the reserved enable bits.
// [RULE15] A condition interrupts only while its flag and enable are set.
// [RULE16] A flag set in the cycle software clears it stays set.
// [RULE17] Slot mask and interrupt enable reset to all zeros.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module tx_slot_gate #(
	parameter int SER_N      = 4,
	parameter int SLOT_COUNT = tx_slot_pkg::SLOT_COUNT
) (
	input  wire logic                           clk,
	input  wire logic                           reset_n,
	input  wire tx_slot_pkg::axil_req_s         axil_req,
	output tx_slot_pkg::axil_rsp_s              axil_rsp,
	input  wire logic [tx_slot_pkg::SLOT_W-1:0] slot_number,
	input  wire logic                           slot_valid,
	input  wire logic [SER_N-1:0]               ser_shift_req,
	input  wire tx_slot_pkg::tx_events_s        tx_events,
	output logic [SER_N-1:0]                    ser_shift_en,
	output logic                                tx_slot_active_bit,
	output logic [7:0]                          tx_status_flags,
	output logic                                tx_interrupt
);

	typedef struct packed {
		logic                           aw_held;
		logic [tx_slot_pkg::ADDR_W-1:0] aw_addr;
		logic                           w_held;
		logic [tx_slot_pkg::DATA_W-1:0] w_data;
		logic [tx_slot_pkg::STRB_W-1:0] w_strb;
		logic                           bvalid;
		logic [1:0]                     bresp;
		logic                           rvalid;
		logic [tx_slot_pkg::DATA_W-1:0] rdata;
		logic [1:0]                     rresp;
		logic [tx_slot_pkg::DATA_W-1:0] slot_mask;
		logic [tx_slot_pkg::DATA_W-1:0] int_enable;
		logic [7:0]                     flags;
		logic [tx_slot_pkg::SLOT_W-1:0] slot_seen;
		logic                           irq;
	} gate_state_s;

	gate_state_s state_ff;
	gate_state_s nxt_state;

	logic                           aw_take;
	logic                           w_take;
	logic                           ar_take;
	logic                           wr_fire;
	logic [7:0]                     flag_set;
	logic [7:0]                     flag_clr;
	logic                           pending;
	logic                           slot_active;
	logic [tx_slot_pkg::DATA_W-1:0] rd_word;
	logic                           rd_hit;

	// Merges the enabled byte lanes of a write into an old register value.
	function automatic logic [tx_slot_pkg::DATA_W-1:0] merge_lanes(
		input logic [tx_slot_pkg::DATA_W-1:0] old_val,
		input logic [tx_slot_pkg::DATA_W-1:0] new_val,
		input logic [tx_slot_pkg::STRB_W-1:0] strb
	);
		logic [tx_slot_pkg::DATA_W-1:0] res;
		res = old_val;
		for (int i = 0; i < tx_slot_pkg::STRB_W; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_val[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// True when an address names one of the implemented words.
	function automatic logic addr_mapped(
		input logic [tx_slot_pkg::ADDR_W-1:0] addr
	);
		logic hit;
		hit = (addr == tx_slot_pkg::OFS_SLOT_MASK)
			| (addr == tx_slot_pkg::OFS_INT_ENABLE)
			| (addr == tx_slot_pkg::OFS_STATUS)
			| (addr == tx_slot_pkg::OFS_SLOT_STATE);
		return hit;
	endfunction

	tx_slot_select #(
		.SER_N(SER_N)
	) u_select (
		.clk          (clk),
		.reset_n      (reset_n),
		.slot_mask    (state_ff.slot_mask),
		.slot_number  (slot_number),
		.slot_valid   (slot_valid),
		.ser_shift_req(ser_shift_req),
		.slot_active  (slot_active),
		.ser_shift_en (ser_shift_en)
	);

	// A slot number past the frame length is not recorded in slot_seen; the slot gating still uses it.
	logic slot_in_range;
	assign slot_in_range = 32'(slot_number) < SLOT_COUNT; // see [RULE1]

	assign aw_take = axil_req.awvalid & ~state_ff.aw_held & ~state_ff.bvalid;
	assign w_take  = axil_req.wvalid & ~state_ff.w_held & ~state_ff.bvalid;
	assign ar_take = axil_req.arvalid & ~state_ff.rvalid;
	assign wr_fire = state_ff.aw_held & state_ff.w_held & ~state_ff.bvalid;

	// Event pulses placed in the status layout.
	always_comb begin
		flag_set = '0;
		flag_set[tx_slot_pkg::ST_DMA_ERR]     = tx_events.dma_err;
		flag_set[tx_slot_pkg::ST_FRAME_START] = tx_events.frame_start;
		flag_set[tx_slot_pkg::ST_DATA_READY]  = tx_events.data_ready;
		flag_set[tx_slot_pkg::ST_FINAL_SLOT]  = tx_events.final_slot;
		flag_set[tx_slot_pkg::ST_CLK_FAIL]    = tx_events.clk_fail;
		flag_set[tx_slot_pkg::ST_SYNC]        = tx_events.unexpected_sync;
		flag_set[tx_slot_pkg::ST_UNDERRUN]    = tx_events.underrun;
	end

	// Status flags clear by writing 1; only lane 0 carries flag bits.
	always_comb begin
		flag_clr = '0;
		if (wr_fire && state_ff.aw_addr == tx_slot_pkg::OFS_STATUS
			&& state_ff.w_strb[0]) begin
			flag_clr = state_ff.w_data[7:0] & tx_slot_pkg::STATUS_FLAG_MASK;
		end
	end

	// Each condition needs both its flag and its own enable bit.
	always_comb begin
		pending = 1'b0;
		pending |= state_ff.flags[tx_slot_pkg::ST_FRAME_START]
			& state_ff.int_enable[tx_slot_pkg::EN_FRAME_START]; // see [RULE6]
		pending |= state_ff.flags[tx_slot_pkg::ST_DATA_READY]
			& state_ff.int_enable[tx_slot_pkg::EN_DATA_READY]; // see [RULE7]
		pending |= state_ff.flags[tx_slot_pkg::ST_FINAL_SLOT]
			& state_ff.int_enable[tx_slot_pkg::EN_FINAL_SLOT]; // see [RULE8]
		pending |= state_ff.flags[tx_slot_pkg::ST_DMA_ERR]
			& state_ff.int_enable[tx_slot_pkg::EN_DMA_ERR]; // see [RULE9]
		pending |= state_ff.flags[tx_slot_pkg::ST_CLK_FAIL]
			& state_ff.int_enable[tx_slot_pkg::EN_CLK_FAIL]; // see [RULE10]
		pending |= state_ff.flags[tx_slot_pkg::ST_SYNC]
			& state_ff.int_enable[tx_slot_pkg::EN_SYNC]; // see [RULE11]
		pending |= state_ff.flags[tx_slot_pkg::ST_UNDERRUN]
			& state_ff.int_enable[tx_slot_pkg::EN_UNDERRUN]; // see [RULE12]
	end

	// Read decode; the error summary is rebuilt from the flags each read.
	always_comb begin
		rd_word = '0;
		rd_hit = addr_mapped(axil_req.araddr);
		case (axil_req.araddr)
			tx_slot_pkg::OFS_SLOT_MASK: begin
				rd_word = state_ff.slot_mask;
			end
			tx_slot_pkg::OFS_INT_ENABLE: begin
				rd_word = state_ff.int_enable
					& tx_slot_pkg::INT_ENABLE_WMASK; // see [RULE13]
			end
			tx_slot_pkg::OFS_STATUS: begin
				rd_word[7:0] = state_ff.flags;
				rd_word[tx_slot_pkg::ST_ANY_ERROR] =
					state_ff.flags[tx_slot_pkg::ST_DMA_ERR]
					| state_ff.flags[tx_slot_pkg::ST_CLK_FAIL]
					| state_ff.flags[tx_slot_pkg::ST_SYNC]
					| state_ff.flags[tx_slot_pkg::ST_UNDERRUN];
			end
			tx_slot_pkg::OFS_SLOT_STATE: begin
				rd_word[tx_slot_pkg::SLOT_W-1:0] = state_ff.slot_seen;
				rd_word[tx_slot_pkg::SLOT_ACTIVE_POS] = slot_active;
			end
			default: begin
				rd_word = '0;
			end
		endcase
	end

	always_comb begin
		nxt_state = state_ff;

		if (aw_take) begin
			nxt_state.aw_held = 1'b1;
			nxt_state.aw_addr = axil_req.awaddr;
		end
		if (w_take) begin
			nxt_state.w_held = 1'b1;
			nxt_state.w_data = axil_req.wdata;
			nxt_state.w_strb = axil_req.wstrb;
		end

		if (wr_fire) begin
			nxt_state.aw_held = 1'b0;
			nxt_state.w_held  = 1'b0;
			nxt_state.bvalid  = 1'b1;
			if (addr_mapped(state_ff.aw_addr)) begin
				nxt_state.bresp = tx_slot_pkg::RESP_OKAY;
			end else begin
				nxt_state.bresp = tx_slot_pkg::RESP_SLVERR;
			end
			case (state_ff.aw_addr)
				tx_slot_pkg::OFS_SLOT_MASK: begin
					nxt_state.slot_mask = merge_lanes(state_ff.slot_mask,
						state_ff.w_data, state_ff.w_strb);
				end
				tx_slot_pkg::OFS_INT_ENABLE: begin
					// Reserved bits are dropped here, so they never store.
					nxt_state.int_enable = merge_lanes(state_ff.int_enable,
						state_ff.w_data, state_ff.w_strb)
						& tx_slot_pkg::INT_ENABLE_WMASK; // see [RULE13]
				end
				default: begin
					nxt_state.int_enable = state_ff.int_enable;
				end
			endcase
		end else if (state_ff.bvalid && axil_req.bready) begin
			nxt_state.bvalid = 1'b0;
		end

		if (ar_take) begin
			nxt_state.rvalid = 1'b1;
			nxt_state.rdata  = rd_word;
			if (rd_hit) begin
				nxt_state.rresp = tx_slot_pkg::RESP_OKAY;
			end else begin
				nxt_state.rresp = tx_slot_pkg::RESP_SLVERR;
			end
		end else if (state_ff.rvalid && axil_req.rready) begin
			nxt_state.rvalid = 1'b0;
		end

		// A set in the same cycle as a clear leaves the flag set.
		nxt_state.flags = ((state_ff.flags & ~flag_clr) | flag_set)
			& tx_slot_pkg::STATUS_FLAG_MASK; // see [RULE16]

		if (slot_valid && slot_in_range) begin
			nxt_state.slot_seen = slot_number; // see [RULE1]
		end

		// Registered so the line is glitch free toward the core.
		nxt_state.irq = pending; // see [RULE5] see [RULE15]
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state_ff <= '0;
			state_ff.slot_mask  <= tx_slot_pkg::SLOT_MASK_RESET; // see [RULE17]
			state_ff.int_enable <= tx_slot_pkg::INT_ENABLE_RESET; // see [RULE17]
			state_ff.flags      <= tx_slot_pkg::STATUS_RESET;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_comb begin
		axil_rsp = '0;
		axil_rsp.awready = ~state_ff.aw_held & ~state_ff.bvalid;
		axil_rsp.wready  = ~state_ff.w_held & ~state_ff.bvalid;
		axil_rsp.bvalid  = state_ff.bvalid;
		axil_rsp.bresp   = state_ff.bresp;
		axil_rsp.arready = ~state_ff.rvalid;
		axil_rsp.rvalid  = state_ff.rvalid;
		axil_rsp.rdata   = state_ff.rdata;
		axil_rsp.rresp   = state_ff.rresp;
	end

	assign tx_slot_active_bit = slot_active;
	assign tx_status_flags    = state_ff.flags;
	assign tx_interrupt       = state_ff.irq;

endmodule // tx_slot_gate
`default_nettype wire

// >>> dv/tx_slot_gate_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module tx_slot_gate_monitor #(
	parameter int SER_N = 4
) (
	input wire logic                    clk,
	input wire logic                    reset_n,
	input wire tx_slot_pkg::axil_req_s  axil_req,
	input wire tx_slot_pkg::axil_rsp_s  axil_rsp,
	input wire logic [8:0]              slot_number,
	input wire logic                    slot_valid,
	input wire logic [SER_N-1:0]        ser_shift_req,
	input wire tx_slot_pkg::tx_events_s tx_events,
	input wire logic [SER_N-1:0]        ser_shift_en,
	input wire logic                    tx_slot_active_bit,
	input wire logic [7:0]              tx_status_flags,
	input wire logic                    tx_interrupt
);
	logic [7:0] ev_flags;
	logic [7:0] rd_addr_ff;
	// Event pulses laid out at the bit positions of their status flags.
	assign ev_flags = {tx_events.dma_err, tx_events.frame_start,
		tx_events.data_ready, tx_events.final_slot, 1'b0,
		tx_events.clk_fail, tx_events.unexpected_sync, tx_events.underrun};
	always_ff @(posedge clk) begin
		if (axil_req.arvalid && axil_rsp.arready) begin
			rd_addr_ff <= axil_req.araddr;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	property p_gate;
		1 |=> ser_shift_en == (tx_slot_active_bit ? $past(ser_shift_req) : '0);
	endproperty
	a_gate: assert property (p_gate)
		else $error("shift enable disagrees with slot activity");
	property p_idle;
		!slot_valid |=> !tx_slot_active_bit && ser_shift_en == '0;
	endproperty
	a_idle: assert property (p_idle)
		else $error("shift enabled outside a valid slot");
	// A mask write between the two samples may legally change the answer.
	property p_mod;
		slot_valid && $past(slot_valid) && !$rose(axil_rsp.bvalid) &&
		slot_number[4:0] == $past(slot_number[4:0])
		|=> $stable(tx_slot_active_bit);
	endproperty
	a_mod: assert property (p_mod)
		else $error("slots sharing a mask bit differ");
	property p_set;
		|ev_flags |=> (tx_status_flags & $past(ev_flags)) == $past(ev_flags);
	endproperty
	a_set: assert property (p_set)
		else $error("event did not set its flag");
	property p_cause;
		tx_interrupt |-> $past(tx_status_flags) != 8'h00;
	endproperty
	a_cause: assert property (p_cause)
		else $error("interrupt without a flag");
	property p_rsv;
		axil_rsp.rvalid && rd_addr_ff == tx_slot_pkg::OFS_INT_ENABLE
		|-> axil_rsp.rdata[31:8] == 24'h00_0000 && !axil_rsp.rdata[6];
	endproperty
	a_rsv: assert property (p_rsv)
		else $error("reserved enable bits read nonzero");
	property p_rhold;
		axil_rsp.rvalid && !axil_req.rready
		|=> axil_rsp.rvalid && $stable(axil_rsp.rdata);
	endproperty
	a_rhold: assert property (p_rhold)
		else $error("read data dropped before taken");
	property p_bresp;
		axil_req.awvalid && axil_rsp.awready && axil_req.wvalid &&
		axil_rsp.wready |-> ##[1:2] axil_rsp.bvalid;
	endproperty
	a_bresp: assert property (p_bresp)
		else $error("write response late");
endmodule // tx_slot_gate_monitor
`default_nettype wire

// >>> dv/tdm_slot_source.sv
`timescale 1ns/1ps
`default_nettype none
module tdm_slot_source #(
	parameter int SER_N = 4,
	parameter int SLOTS = 384
) (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        run,
	output logic [8:0]       slot_number,
	output logic             slot_valid,
	output logic [SER_N-1:0] ser_shift_req
);
	int count;
	// Idle slot lines toggle so that a stale number is never reused.
	always @(posedge clk) begin
		ser_shift_req <= SER_N'($urandom);
		if (!reset_n) begin
			count <= 0;
			slot_valid <= 1'b0;
			slot_number <= 9'h000;
		end else if (run) begin
			slot_valid <= 1'b1;
			slot_number <= 9'(count);
			// A real slot spans many clocks, so a number may repeat for several clocks.
			if ($urandom % 2 == 0) begin
				count <= (count == SLOTS - 1) ? 0 : count + 1;
			end
		end else begin
			slot_valid <= 1'b0;
			slot_number <= ~slot_number;
		end
	end
endmodule // tdm_slot_source
`default_nettype wire

// >>> dv/tx_slot_mask_and_irq_enable_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tx_slot_mask_and_irq_enable_tb;
	localparam logic [7:0] EN = tx_slot_pkg::OFS_INT_ENABLE;
	localparam logic [7:0] ST = tx_slot_pkg::OFS_STATUS;
	localparam logic [7:0] MK = tx_slot_pkg::OFS_SLOT_MASK;
	logic                    clk;
	logic                    reset_n;
	tx_slot_pkg::axil_req_s  req;
	tx_slot_pkg::axil_rsp_s  rsp;
	tx_slot_pkg::tx_events_s ev;
	logic [8:0]              slot_number;
	logic                    slot_valid;
	logic [3:0]              ser_shift_req;
	logic [3:0]              ser_shift_en;
	logic [3:0]              exp_en;
	logic                    act;
	logic                    exp_act;
	logic                    irq;
	logic                    run;
	logic                    chk_on;
	logic [7:0]              flags;
	logic [31:0]             mask_m;
	int                      fails;
	int                      compares;
	int                      en_pos[7] = '{0, 1, 2, 3, 4, 5, 7};
	int                      st_pos[7] = '{0, 1, 2, 7, 4, 5, 6};
	tx_slot_gate #(.SER_N(4)) DUT (
		.clk(clk), .reset_n(reset_n), .axil_req(req), .axil_rsp(rsp),
		.slot_number(slot_number), .slot_valid(slot_valid),
		.ser_shift_req(ser_shift_req), .tx_events(ev),
		.ser_shift_en(ser_shift_en), .tx_slot_active_bit(act),
		.tx_status_flags(flags), .tx_interrupt(irq)
	);
	tdm_slot_source #(.SER_N(4)) codec (
		.clk(clk), .reset_n(reset_n), .run(run), .slot_number(slot_number),
		.slot_valid(slot_valid), .ser_shift_req(ser_shift_req)
	);
	always #2.5 clk = ~clk;
	task automatic complete_run;
		if (fails == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
		compares++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Gating model: outputs lag the sampled slot by one edge.
	always @(posedge clk) begin
		if (chk_on) begin
			chk("shift enable", 32'(exp_en), 32'(ser_shift_en));
			chk("slot active", 32'(exp_act), 32'(act));
		end
		exp_act = slot_valid && mask_m[slot_number % 32];
		exp_en = exp_act ? ser_shift_req : 4'h0;
	end
	task automatic wr(input logic [7:0] a, logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge clk);
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= 4'hf;
		req.bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
			if (rsp.bvalid) break;
		end
		req.bready <= 1'b0;
		r = rsp.bresp;
		if (n == 50) begin fails++; complete_run; end
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, logic [1:0] r);
		int n;
		@(posedge clk);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'($urandom % 2);
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
			if (rsp.rvalid && req.rready) break;
			// A late ready makes the slave hold its answer for a cycle.
			if (rsp.rvalid) req.rready <= 1'b1;
		end
		req.rready <= 1'b0;
		d = rsp.rdata;
		r = rsp.rresp;
		if (n == 50) begin fails++; complete_run; end
	endtask
	task automatic pulse(input int i);
		@(posedge clk);
		ev <= tx_slot_pkg::tx_events_s'(7'h01 << i);
		@(posedge clk);
		ev <= '0;
		repeat (3) @(posedge clk);
		#1;
	endtask
	initial begin
		logic [31:0] d;
		logic [31:0] b;
		logic [31:0] f;
		logic [31:0] masks[3];
		logic [1:0] r;
		int i;
		clk = 1'b0;
		reset_n = 1'b0;
		req = '0;
		ev = '0;
		run = 1'b0;
		chk_on = 1'b0;
		mask_m = 32'h0000_0000;
		fails = 0;
		compares = 0;
		void'($urandom(17538));
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		for (i = 0; i < 3; i++) begin
			rd(8'(MK + 4 * i), d, r);
			chk("reset value", 32'h0000_0000, d);
			chk("rresp", 32'(tx_slot_pkg::RESP_OKAY), 32'(r));
		end
		wr(EN, 32'hffff_ffff, r);
		rd(EN, d, r);
		chk("enable readback", 32'h0000_00bf, d);
		wr(8'h10, 32'h1234_5678, r);
		chk("bresp", 32'(tx_slot_pkg::RESP_SLVERR), 32'(r));
		rd(8'h10, d, r);
		chk("rresp", 32'(tx_slot_pkg::RESP_SLVERR), 32'(r));
		masks = '{32'h0000_0000, $urandom, 32'hffff_ffff};
		for (i = 0; i < 3; i++) begin
			wr(MK, masks[i], r);
			rd(MK, d, r);
			chk("slot mask", masks[i], d);
			mask_m = masks[i];
			chk_on <= 1'b1;
			// Random stalls leave the codec idle between slots.
			repeat (1200) begin
				@(posedge clk);
				run <= ($urandom % 4) != 0;
			end
			run <= 1'b0;
			chk_on <= 1'b0;
		end
		for (i = 0; i < 7; i++) begin
			b = 32'h0000_0001 << en_pos[i];
			f = 32'h0000_0001 << st_pos[i];
			wr(EN, b, r);
			pulse(i);
			chk("flags", f, 32'(flags));
			chk("irq", 32'h0000_0001, 32'(irq));
			wr(ST, f, r);
			repeat (2) @(posedge clk);
			#1;
			chk("irq cleared", 32'h0000_0000, 32'(irq));
			wr(EN, 32'h0000_00bf & ~b, r);
			pulse(i);
			chk("irq masked", 32'h0000_0000, 32'(irq));
			wr(ST, f, r);
		end
		wr(EN, 32'h0000_0001, r);
		pulse(0);
		fork
			wr(ST, 32'h0000_0001, r);
			begin
				int k;
				for (k = 0; k < 50; k++) begin
					@(posedge clk);
					if (req.awvalid && rsp.awready) break;
				end
				ev <= tx_slot_pkg::tx_events_s'(7'h01);
				@(posedge clk);
				ev <= '0;
			end
		join
		repeat (2) @(posedge clk);
		#1;
		chk("flag kept", 32'h0000_0001, 32'(flags));
		chk("irq kept", 32'h0000_0001, 32'(irq));
		complete_run;
	end
endmodule // tx_slot_mask_and_irq_enable_tb
bind tx_slot_gate tx_slot_gate_monitor #(.SER_N(SER_N)) mon (
	.clk(clk), .reset_n(reset_n), .axil_req(axil_req), .axil_rsp(axil_rsp),
	.slot_number(slot_number), .slot_valid(slot_valid),
	.ser_shift_req(ser_shift_req), .tx_events(tx_events),
	.ser_shift_en(ser_shift_en), .tx_slot_active_bit(tx_slot_active_bit),
	.tx_status_flags(tx_status_flags), .tx_interrupt(tx_interrupt)
);
`default_nettype wire
